// file: hw/amfl_conv_hold.sv
`timescale 1ns/1ps
module amfl_conv_hold #(
   parameter int W = 12
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] conv_code,
   input  wire logic         conv_valid,
   input  wire logic         rd_high,
   input  wire logic         rd_low,
   output logic [W-1:0]      shown_q
);

   logic         lock_q;
   logic         pend_q;
   logic [W-1:0] pend_code_q;

   ////////////////////////////////////////////////////////////////////////////
   // High read locks the pair until the low read, so both halves match
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lock_q <= 1'b0;
      end else if (rd_low) begin
         lock_q <= 1'b0;
      end else if (rd_high) begin
         lock_q <= 1'b1;
      end
   end

   // A conversion landing with or during the lock waits; only the newest is kept
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_q      <= 1'b0;
         pend_code_q <= '0;
      end else if (conv_valid && (lock_q || rd_high) && !rd_low) begin
         pend_q      <= 1'b1;
         pend_code_q <= conv_code;
      end else if (!lock_q || rd_low) begin
         pend_q      <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         shown_q <= '0;
      end else if (conv_valid && !rd_high && (!lock_q || rd_low)) begin
         shown_q <= conv_code;
      end else if (pend_q && (!lock_q || rd_low)) begin
         shown_q <= pend_code_q;
      end
   end

endmodule

// file: hw/amfl_fault_latch.sv
// Contract
// - Protection latch 0x49: bit7 brownout mute, bit6 brownout infinite hold.
// - Bits 5,4,3: limiter max attenuation, supply below inflection, limiter active.
// - Bit2 port clock error; its cause is latched at 0x51.
// - Bit1 overcurrent, bit0 overtemperature.
// - 0x4A: bit6 fuse checksum error, bit0 gain limiter; bits 7,2,1 zero.
// - 0x4A bit5 reads 1 once a load diagnostic run has completed.
// - 0x4A bits 4-3 hold load diagnostic result: normal, open, short.
// - 0x4B: bit7 internal clock loop error, bit5 battery undervoltage.
// - 0x4F bits 7-4: die over 105, 115, 125, 135 degrees.
// - 0x4F bits 3-0: regulator under, over, overload; power stage lockout.
// - 0x50 bits 7,6 thermal thresholds two, one; bit5 supply gap low.
// - 0x50 bit4 brownout active; bits 3-0 brownout levels three to zero.
// - 0x51 bit2 set for invalid ratio or rate; bits 7-3 zero.
// - 0x51 bit1 inverted: 0 means rate change detected.
// - 0x51 bit0 set when ratio changed during operation.
// - Battery code 12 bits: high byte 0x52, low nibble 0x53[7:4].
// - Power stage code 12 bits: high byte 0x54, low nibble 0x55[7:4].
// - Temperature code 8 bits at 0x56.
// - Writing 1 to latch clear empties all latches; bit self clears.
// - Pin mode: live, latched, one pulse, or repeated pulses.
// - Mask bit 1 keeps an event off the interrupt pin.
`timescale 1ns/1ps
module amfl_fault_latch #(
   parameter int PULSE_CYC  = amfl_pkg::AMFL_PULSE_CYC,
   parameter int PERIOD_CYC = amfl_pkg::AMFL_PERIOD_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_page,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata_q,
   input  wire logic [7:0]  live_prot,
   input  wire logic        fuse_checksum_error,
   input  wire logic        gain_limiter,
   input  wire logic        load_diag_finish,
   input  wire logic [1:0]  load_diag_outcome,
   input  wire logic        pll_error,
   input  wire logic        battery_undervolt,
   input  wire logic [7:0]  live_therm,
   input  wire logic [7:0]  live_brownout,
   input  wire logic        cause_invalid,
   input  wire logic        cause_rate,
   input  wire logic        cause_ratio,
   input  wire logic [7:0]  mask_prot,
   input  wire logic [7:0]  mask_diag,
   input  wire logic [7:0]  mask_pll_bat,
   input  wire logic [7:0]  mask_therm,
   input  wire logic [7:0]  mask_brownout,
   input  wire logic [11:0] battery_conversion_code,
   input  wire logic        battery_conv_valid,
   input  wire logic [11:0] power_stage_conversion_code,
   input  wire logic        power_stage_conv_valid,
   input  wire logic [7:0]  temperature_conversion_code,
   input  wire logic        temperature_conv_valid,
   output logic             interrupt_pin_b_q
);

   localparam int CW = $clog2(PERIOD_CYC + PULSE_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Set wins over clear, so an event in the clear cycle survives
   function automatic logic [7:0] amfl_latch(
      input logic [7:0] q,
      input logic [7:0] ev,
      input logic       clr,
      input logic [7:0] impl
   );
      logic [7:0] kept;
      kept = clr ? amfl_pkg::AMFL_LATCH_RESET : q;
      return (kept | ev) & impl;
   endfunction

   function automatic logic amfl_hit(
      input logic [7:0] page,
      input logic [7:0] addr,
      input logic [7:0] ofs
   );
      return (page == amfl_pkg::AMFL_PAGE_MAIN) && (addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0]  prot_q;
   logic [7:0]  diag_q;
   logic [7:0]  pll_bat_q;
   logic [7:0]  therm_q;
   logic [7:0]  brownout_q;
   logic [7:0]  cause_q;
   logic [7:0]  cfg_q;
   logic [1:0]  irq_pin_mode;
   logic        latch_clear_control;
   logic [7:0]  live_diag;
   logic [7:0]  live_pll_bat;
   logic [7:0]  cause_ev;
   logic        port_clock_error_seen;
   logic        load_diag_done;
   logic [1:0]  load_diag_result;
   logic        rd_bat_high;
   logic        rd_bat_low;
   logic        rd_pwr_high;
   logic        rd_pwr_low;
   logic [11:0] bat_shown;
   logic [11:0] pwr_shown;
   logic [7:0]  temp_shown;
   logic        live_any;
   logic        latched_any;
   logic        live_any_q;
   logic [CW-1:0] once_cnt_q;
   logic [CW-1:0] rept_cnt_q;
   logic        irq_active;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt configuration register

   assign irq_pin_mode = cfg_q[amfl_pkg::AMFL_BIT_MODE_LO +: 2];

   // Clear bit is never stored: a write of 1 is a one-cycle action
   assign latch_clear_control = reg_wr &&
      amfl_hit(reg_page, reg_addr, amfl_pkg::AMFL_OFS_INT_CFG) &&
      reg_wdata[amfl_pkg::AMFL_BIT_LATCH_CLEAR];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= amfl_pkg::AMFL_CFG_RESET;
      end else if (reg_wr && amfl_hit(reg_page, reg_addr, amfl_pkg::AMFL_OFS_INT_CFG)) begin
         cfg_q <= reg_wdata;
         cfg_q[amfl_pkg::AMFL_BIT_LATCH_CLEAR] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Live vectors in latched register layout

   always_comb begin
      live_diag = 8'h00;
      live_diag[amfl_pkg::AMFL_BIT_FUSE_CRC]  = fuse_checksum_error;
      live_diag[amfl_pkg::AMFL_BIT_DIAG_DONE] = load_diag_finish;
      live_diag[amfl_pkg::AMFL_BIT_GAIN_LIM]  = gain_limiter;
   end

   always_comb begin
      live_pll_bat = 8'h00;
      live_pll_bat[amfl_pkg::AMFL_BIT_PLL_ERR] = pll_error;
      live_pll_bat[amfl_pkg::AMFL_BIT_BAT_UV]  = battery_undervolt;
   end

   assign port_clock_error_seen = live_prot[amfl_pkg::AMFL_BIT_PORT_CLK_ERR];

   // Cause bits only count alongside a port clock error
   always_comb begin
      cause_ev = 8'h00;
      if (port_clock_error_seen) begin
         cause_ev[amfl_pkg::AMFL_BIT_CAUSE_INVALID] = cause_invalid;
         cause_ev[amfl_pkg::AMFL_BIT_CAUSE_RATE]    = !cause_rate;
         cause_ev[amfl_pkg::AMFL_BIT_CAUSE_RATIO]   = cause_ratio;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Latched event registers

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prot_q <= amfl_pkg::AMFL_LATCH_RESET;
      end else begin
         prot_q <= amfl_latch(prot_q, live_prot, latch_clear_control,
                              amfl_pkg::AMFL_IMPL_PROT);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pll_bat_q <= amfl_pkg::AMFL_LATCH_RESET;
      end else begin
         pll_bat_q <= amfl_latch(pll_bat_q, live_pll_bat, latch_clear_control,
                                 amfl_pkg::AMFL_IMPL_PLL_BAT);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         therm_q <= amfl_pkg::AMFL_LATCH_RESET;
      end else begin
         therm_q <= amfl_latch(therm_q, live_therm, latch_clear_control,
                               amfl_pkg::AMFL_IMPL_THERM);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         brownout_q <= amfl_pkg::AMFL_LATCH_RESET;
      end else begin
         brownout_q <= amfl_latch(brownout_q, live_brownout, latch_clear_control,
                                  amfl_pkg::AMFL_IMPL_BROWNOUT);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cause_q <= amfl_pkg::AMFL_LATCH_RESET;
      end else begin
         cause_q <= amfl_latch(cause_q, cause_ev, latch_clear_control,
                               amfl_pkg::AMFL_IMPL_CLK_CAUSE);
      end
   end

   // Diagnostic flags; the result field is a value, taken with each finish
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         diag_q <= amfl_pkg::AMFL_LATCH_RESET;
      end else begin
         diag_q <= amfl_latch(diag_q, live_diag, latch_clear_control,
                              amfl_pkg::AMFL_IMPL_DIAG_FLAGS);
         if (load_diag_finish) begin
            diag_q[amfl_pkg::AMFL_BIT_RESULT_LO +: 2] <= load_diag_outcome;
         end else if (!latch_clear_control) begin
            diag_q[amfl_pkg::AMFL_BIT_RESULT_LO +: 2] <=
               diag_q[amfl_pkg::AMFL_BIT_RESULT_LO +: 2];
         end
      end
   end

   assign load_diag_done   = diag_q[amfl_pkg::AMFL_BIT_DIAG_DONE];
   assign load_diag_result = diag_q[amfl_pkg::AMFL_BIT_RESULT_LO +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // Conversion readback

   assign rd_bat_high = reg_rd && amfl_hit(reg_page, reg_addr, amfl_pkg::AMFL_OFS_BAT_HIGH);
   assign rd_bat_low  = reg_rd && amfl_hit(reg_page, reg_addr, amfl_pkg::AMFL_OFS_BAT_LOW);
   assign rd_pwr_high = reg_rd && amfl_hit(reg_page, reg_addr, amfl_pkg::AMFL_OFS_PWR_HIGH);
   assign rd_pwr_low  = reg_rd && amfl_hit(reg_page, reg_addr, amfl_pkg::AMFL_OFS_PWR_LOW);

   amfl_conv_hold #(
      .W(12)
   ) u_bat_hold (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .conv_code  (battery_conversion_code),
      .conv_valid (battery_conv_valid),
      .rd_high    (rd_bat_high),
      .rd_low     (rd_bat_low),
      .shown_q    (bat_shown)
   );

   amfl_conv_hold #(
      .W(12)
   ) u_pwr_hold (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .conv_code  (power_stage_conversion_code),
      .conv_valid (power_stage_conv_valid),
      .rd_high    (rd_pwr_high),
      .rd_low     (rd_pwr_low),
      .shown_q    (pwr_shown)
   );

   // Single byte, so no lock is needed
   amfl_conv_hold #(
      .W(8)
   ) u_temp_hold (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .conv_code  (temperature_conversion_code),
      .conv_valid (temperature_conv_valid),
      .rd_high    (1'b0),
      .rd_low     (1'b0),
      .shown_q    (temp_shown)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= amfl_pkg::AMFL_READ_UNMAPPED;
      end else if (reg_rd) begin
         if (reg_page != amfl_pkg::AMFL_PAGE_MAIN) begin
            reg_rdata_q <= amfl_pkg::AMFL_READ_UNMAPPED;
         end else begin
            case (reg_addr)
               amfl_pkg::AMFL_OFS_PROT: begin
                  reg_rdata_q <= prot_q;
               end
               amfl_pkg::AMFL_OFS_DIAG: begin
                  reg_rdata_q <= diag_q;
               end
               amfl_pkg::AMFL_OFS_PLL_BAT: begin
                  reg_rdata_q <= pll_bat_q;
               end
               amfl_pkg::AMFL_OFS_THERM: begin
                  reg_rdata_q <= therm_q;
               end
               amfl_pkg::AMFL_OFS_BROWNOUT: begin
                  reg_rdata_q <= brownout_q;
               end
               amfl_pkg::AMFL_OFS_CLK_CAUSE: begin
                  reg_rdata_q <= cause_q;
               end
               amfl_pkg::AMFL_OFS_BAT_HIGH: begin
                  reg_rdata_q <= bat_shown[11:4];
               end
               amfl_pkg::AMFL_OFS_BAT_LOW: begin
                  reg_rdata_q <= {bat_shown[3:0], 4'h0};
               end
               amfl_pkg::AMFL_OFS_PWR_HIGH: begin
                  reg_rdata_q <= pwr_shown[11:4];
               end
               amfl_pkg::AMFL_OFS_PWR_LOW: begin
                  reg_rdata_q <= {pwr_shown[3:0], 4'h0};
               end
               amfl_pkg::AMFL_OFS_TEMP: begin
                  reg_rdata_q <= temp_shown;
               end
               amfl_pkg::AMFL_OFS_INT_CFG: begin
                  reg_rdata_q <= cfg_q;
               end
               default: begin
                  reg_rdata_q <= amfl_pkg::AMFL_READ_UNMAPPED;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt pin

   assign live_any = |(live_prot & ~mask_prot) |
                     |(live_diag & ~mask_diag) |
                     |(live_pll_bat & ~mask_pll_bat) |
                     |(live_therm & ~mask_therm) |
                     |(live_brownout & ~mask_brownout);

   // Result field is a value, not an event, so it never drives the pin
   assign latched_any = |(prot_q & ~mask_prot) |
                        |(diag_q & amfl_pkg::AMFL_IMPL_DIAG_FLAGS & ~mask_diag) |
                        |(pll_bat_q & ~mask_pll_bat) |
                        |(therm_q & ~mask_therm) |
                        |(brownout_q & ~mask_brownout);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         live_any_q <= 1'b0;
      end else begin
         live_any_q <= live_any;
      end
   end

   // One pulse per rise of live_any; a rise during a pulse restarts it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         once_cnt_q <= '0;
      end else if (irq_pin_mode != amfl_pkg::AMFL_MODE_PULSE_ONCE) begin
         once_cnt_q <= '0;
      end else if (live_any && !live_any_q) begin
         once_cnt_q <= CW'(PULSE_CYC);
      end else if (once_cnt_q != '0) begin
         once_cnt_q <= once_cnt_q - 1'b1;
      end
   end

   // Free phase counter while any unmasked latch stands
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rept_cnt_q <= '0;
      end else if (irq_pin_mode != amfl_pkg::AMFL_MODE_PULSE_REPT || !latched_any) begin
         rept_cnt_q <= '0;
      end else if (rept_cnt_q == CW'(PERIOD_CYC - 1)) begin
         rept_cnt_q <= '0;
      end else begin
         rept_cnt_q <= rept_cnt_q + 1'b1;
      end
   end

   always_comb begin
      case (irq_pin_mode)
         amfl_pkg::AMFL_MODE_LIVE: begin
            irq_active = live_any;
         end
         amfl_pkg::AMFL_MODE_LATCHED: begin
            irq_active = latched_any;
         end
         amfl_pkg::AMFL_MODE_PULSE_ONCE: begin
            irq_active = (once_cnt_q != '0);
         end
         amfl_pkg::AMFL_MODE_PULSE_REPT: begin
            irq_active = latched_any && (rept_cnt_q < CW'(PULSE_CYC));
         end
         default: begin
            irq_active = 1'b0;
         end
      endcase
   end

   // Registered so the pin never glitches on decode
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         interrupt_pin_b_q <= 1'b1;
      end else begin
         interrupt_pin_b_q <= !irq_active;
      end
   end

endmodule

// file: hw/amfl_pkg.sv
package amfl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets, page 0
   localparam logic [7:0] AMFL_PAGE_MAIN        = 8'h00;
   localparam logic [7:0] AMFL_OFS_PROT         = 8'h49;
   localparam logic [7:0] AMFL_OFS_DIAG         = 8'h4a;
   localparam logic [7:0] AMFL_OFS_PLL_BAT      = 8'h4b;
   localparam logic [7:0] AMFL_OFS_THERM        = 8'h4f;
   localparam logic [7:0] AMFL_OFS_BROWNOUT     = 8'h50;
   localparam logic [7:0] AMFL_OFS_CLK_CAUSE    = 8'h51;
   localparam logic [7:0] AMFL_OFS_BAT_HIGH     = 8'h52;
   localparam logic [7:0] AMFL_OFS_BAT_LOW      = 8'h53;
   localparam logic [7:0] AMFL_OFS_PWR_HIGH     = 8'h54;
   localparam logic [7:0] AMFL_OFS_PWR_LOW      = 8'h55;
   localparam logic [7:0] AMFL_OFS_TEMP         = 8'h56;
   localparam logic [7:0] AMFL_OFS_INT_CFG      = 8'h5c;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] AMFL_LATCH_RESET      = 8'h00;
   localparam logic [7:0] AMFL_CFG_RESET        = 8'h19;
   localparam logic [7:0] AMFL_READ_UNMAPPED    = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Implemented flag bits per latched register; the rest read zero, except the 0x4A result field in bits 4-3
   localparam logic [7:0] AMFL_IMPL_PROT        = 8'hff;
   localparam logic [7:0] AMFL_IMPL_DIAG_FLAGS  = 8'h61;
   localparam logic [7:0] AMFL_IMPL_PLL_BAT     = 8'ha0;
   localparam logic [7:0] AMFL_IMPL_THERM       = 8'hff;
   localparam logic [7:0] AMFL_IMPL_BROWNOUT    = 8'hff;
   localparam logic [7:0] AMFL_IMPL_CLK_CAUSE   = 8'h07;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int AMFL_BIT_PORT_CLK_ERR  = 2;
   localparam int AMFL_BIT_FUSE_CRC      = 6;
   localparam int AMFL_BIT_DIAG_DONE     = 5;
   localparam int AMFL_BIT_RESULT_LO     = 3;
   localparam int AMFL_BIT_GAIN_LIM      = 0;
   localparam int AMFL_BIT_PLL_ERR       = 7;
   localparam int AMFL_BIT_BAT_UV        = 5;
   localparam int AMFL_BIT_CAUSE_INVALID = 2;
   localparam int AMFL_BIT_CAUSE_RATE    = 1;
   localparam int AMFL_BIT_CAUSE_RATIO   = 0;
   localparam int AMFL_BIT_LATCH_CLEAR   = 2;
   localparam int AMFL_BIT_MODE_LO       = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt pin modes
   localparam logic [1:0] AMFL_MODE_LIVE        = 2'h0;
   localparam logic [1:0] AMFL_MODE_LATCHED     = 2'h1;
   localparam logic [1:0] AMFL_MODE_PULSE_ONCE  = 2'h2;
   localparam logic [1:0] AMFL_MODE_PULSE_REPT  = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int AMFL_CLK_KHZ      = 40000;
   localparam int AMFL_PULSE_MS     = 2;
   localparam int AMFL_PERIOD_MS    = 4;
   localparam int AMFL_PULSE_CYC    = AMFL_PULSE_MS * AMFL_CLK_KHZ;
   localparam int AMFL_PERIOD_CYC   = AMFL_PERIOD_MS * AMFL_CLK_KHZ;

endpackage

// file: verif/amfl_fault_latch_assertions.sv
`timescale 1ns/1ps
module amfl_chk (
   input wire logic       core_clk,
   input wire logic       rst_b,
   input wire logic [7:0] reg_page,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_q,
   input wire logic [7:0] live_prot,
   input wire logic [7:0] temperature_conversion_code,
   input wire logic       temperature_conv_valid
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   // Page 0 only; other pages read zero
   wire rd0 = reg_rd && reg_page == 8'h00;
   wire clr = reg_wr && reg_page == 8'h00 && reg_addr == 8'h5c && reg_wdata[2];
   ////////////////////////////////////////////////////////////////////////////
   prot_sticky_a: assert property (rd0 && reg_addr == 8'h49 && $past(rst_b) |=>
      (reg_rdata_q & $past(live_prot, 2)) == $past(live_prot, 2)) else $error("flag lost");
   diag_rsvd_a: assert property (rd0 && reg_addr == 8'h4a |=>
      (reg_rdata_q & 8'h86) == 8'h00) else $error("diag reserved set");
   pll_rsvd_a: assert property (rd0 && reg_addr == 8'h4b |=>
      (reg_rdata_q & 8'h5f) == 8'h00) else $error("pll reserved set");
   cause_rsvd_a: assert property (rd0 && reg_addr == 8'h51 |=>
      reg_rdata_q[7:3] == 5'h00) else $error("cause reserved set");
   low_nibble_a: assert property (rd0 && (reg_addr == 8'h53 || reg_addr == 8'h55)
      |=> reg_rdata_q[3:0] == 4'h0) else $error("low byte nibble set");
   temp_read_a: assert property (rd0 && reg_addr == 8'h56
      && $past(temperature_conv_valid) && $past(rst_b)
      |=> reg_rdata_q == $past(temperature_conversion_code, 2))
      else $error("temperature stale");
   clear_all_a: assert property ((clr && live_prot == 8'h00) ##1 live_prot == 8'h00
      ##1 (rd0 && reg_addr == 8'h49) |=> reg_rdata_q == 8'h00) else $error("clear failed");
   // Coherent pairs rely on read data standing still
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
      else $error("read data moved");
   pair_c: cover property (rd0 && reg_addr == 8'h52 ##2 rd0 && reg_addr == 8'h53);
   clear_c: cover property (clr);
   temp_c: cover property (rd0 && reg_addr == 8'h56 && $past(temperature_conv_valid));
endmodule
bind amfl_fault_latch amfl_chk chk (.core_clk, .rst_b, .reg_page, .reg_addr, .reg_wr,
   .reg_wdata, .reg_rd, .reg_rdata_q, .live_prot, .temperature_conversion_code,
   .temperature_conv_valid);

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_page = 8'h00;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  mask_prot = 8'h00;
   logic [7:0]  mask_diag = 8'h00, mask_pll_bat = 8'h00, mask_therm = 8'h00;
   logic [7:0]  mask_brownout = 8'h00;
   logic [33:0] evs = '0;
   logic [34:0] cvs = '0;
   logic [7:0]  reg_rdata_q, live_prot, live_therm, live_brownout, temperature_conversion_code;
   logic [11:0] battery_conversion_code, power_stage_conversion_code;
   logic [1:0]  load_diag_outcome;
   logic        interrupt_pin_b_q, fuse_checksum_error, gain_limiter, pll_error;
   logic        battery_undervolt, cause_invalid, cause_rate, cause_ratio, load_diag_finish;
   logic        battery_conv_valid, power_stage_conv_valid, temperature_conv_valid;
   logic        rd_seen = 1'b0;
   logic [7:0]  exp_q[$];
   int          n_fail = 0;
   int          check_count = 0;
   logic [7:0]  ofs[12] = '{8'h49, 8'h4a, 8'h4b, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54,
                           8'h55, 8'h56, 8'h4c};
   assign {live_prot, live_therm, live_brownout, fuse_checksum_error, gain_limiter, pll_error,
           battery_undervolt, cause_invalid, cause_rate, cause_ratio, load_diag_finish,
           load_diag_outcome} = evs;
   assign {battery_conversion_code, battery_conv_valid, power_stage_conversion_code,
           power_stage_conv_valid, temperature_conversion_code, temperature_conv_valid} = cvs;
   always #12.5 core_clk = ~core_clk;
   // Short pulse counts keep the run brief
   amfl_fault_latch #(.PULSE_CYC(4), .PERIOD_CYC(8)) dut (.*);
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(logic [7:0] seen, logic [7:0] want);
      check_count++;
      if (seen !== want) begin
         n_fail++;
         $display("FAIL %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] want, logic [7:0] pg = 8'h00);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      reg_page <= pg;
      exp_q.push_back(want);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic wr(logic [7:0] d, logic [7:0] lp = 8'h00);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= 8'h5c;
      reg_page <= 8'h00;
      reg_wdata <= d;
      evs[33:26] <= lp;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      evs[33:26] <= 8'h00;
   endtask
   task automatic ev(logic [33:0] v);
      @(posedge core_clk);
      evs <= v;
      @(posedge core_clk);
      evs <= '0;
   endtask
   // Codes change while not valid: must be ignored
   task automatic cv(logic [11:0] a, logic [11:0] b);
      @(posedge core_clk);
      cvs <= {a, 1'b1, b, 1'b1, a[11:4], 1'b1};
      @(posedge core_clk);
      cvs <= {~a, 1'b0, ~b, 1'b0, 8'h00, 1'b0};
      reg_rd <= 1'b1;
      reg_addr <= 8'h56;
      reg_page <= 8'h00;
      exp_q.push_back(a[11:4]);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic pin(int s, int n, logic [7:0] want);
      int lows;
      lows = 0;
      repeat (s) @(posedge core_clk);
      repeat (n) begin
         @(posedge core_clk);
         #1 lows += (interrupt_pin_b_q === 1'b0);
      end
      check(8'(lows), want);
   endtask
   always @(posedge core_clk) begin
      if (rd_seen) begin
         check(reg_rdata_q, exp_q.pop_front());
      end
      rd_seen <= reg_rd;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0]  p, t, b;
      logic [6:0]  f;
      logic [1:0]  o;
      logic [11:0] c1, c2, d1, d2;
      void'($urandom(62));
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      foreach (ofs[i]) rd(ofs[i], 8'h00);
      $display("reset test done");
      repeat (3) begin
         p = 8'($urandom());
         t = 8'($urandom());
         b = 8'($urandom());
         f = 7'($urandom());
         o = 2'($urandom_range(2, 0));
         p[2] = 1'b1;
         ev({p, t, b, f, 1'b1, o});
         rd(8'h49, p);
         rd(8'h49, 8'h00, 8'h01);
         rd(8'h4a, {1'b0, f[6], 1'b1, o, 2'h0, f[5]});
         rd(8'h4b, {f[4], 1'b0, f[3], 5'h00});
         rd(8'h4f, t);
         rd(8'h50, b);
         rd(8'h51, {5'h00, f[2], ~f[1], f[0]});
         pin(0, 4, 8'h04);
         wr(8'h1d);
         foreach (ofs[i]) rd(ofs[i], 8'h00);
         pin(1, 4, 8'h00);
      end
      wr(8'h1d, 8'h01);
      rd(8'h49, 8'h01);
      rd(8'h5c, 8'h19);
      $display("latch test done");
      c1 = 12'($urandom());
      c2 = 12'($urandom());
      d1 = 12'($urandom());
      d2 = 12'($urandom());
      cv(c1, d1);
      rd(8'h52, c1[11:4]);
      cv(c2, d2);
      rd(8'h53, {c1[3:0], 4'h0});
      rd(8'h52, c2[11:4]);
      rd(8'h53, {c2[3:0], 4'h0});
      rd(8'h54, d2[11:4]);
      cv(c1, d1);
      rd(8'h55, {d2[3:0], 4'h0});
      rd(8'h55, {d1[3:0], 4'h0});
      // New code in the very cycle of the high read must wait for the low read
      @(posedge core_clk);
      cvs <= {c2, 1'b1, d2, 1'b1, 8'h00, 1'b0};
      reg_rd <= 1'b1;
      reg_addr <= 8'h52;
      exp_q.push_back(c1[11:4]);
      @(posedge core_clk);
      cvs <= '0;
      reg_rd <= 1'b0;
      rd(8'h53, {c1[3:0], 4'h0});
      $display("conversion test done");
      wr(8'h18);
      @(posedge core_clk);
      evs[25:18] <= 8'h02;
      pin(0, 4, 8'h04);
      @(posedge core_clk);
      evs[25:18] <= 8'h00;
      pin(0, 4, 8'h00);
      wr(8'h1a);
      @(posedge core_clk);
      evs[17:10] <= 8'h04;
      pin(0, 12, 8'h04);
      @(posedge core_clk);
      evs[17:10] <= 8'h00;
      wr(8'h1b);
      pin(4, 16, 8'h08);
      wr(8'h1f);
      pin(3, 16, 8'h00);
      wr(8'h1d);
      ev({8'h80, 26'h0});
      pin(1, 4, 8'h04);
      @(posedge core_clk);
      mask_prot <= 8'h80;
      pin(1, 4, 8'h00);
      @(posedge core_clk);
      mask_prot <= 8'h00;
      pin(1, 4, 8'h04);
      $display("pin test done");
      final_report();
   end
   // About thirteen times the expected run
   initial begin
      #100000;
      n_fail++;
      $display("FAIL %0t watchdog", $time);
      final_report();
   end
endmodule
